// >>> logic/twd_pkg.sv
// constants and types for the tick timer and watchdog block
package twd_pkg;

  localparam logic [7:0] ADR_CFG = 8'h00;
  localparam logic [7:0] ADR_PRE = 8'h04;
  localparam logic [7:0] ADR_RLD = 8'h08;
  localparam logic [7:0] ADR_CSR = 8'h0C;
  localparam logic [7:0] ADR_WDC = 8'h10;
  localparam logic [7:0] ADR_WDM = 8'h14;

  localparam int CFG_LCFG = 0;
  localparam int CFG_LPRE = 1;
  localparam int CFG_LTCK = 2;
  localparam int CFG_LWDC = 3;
  localparam int CFG_WSEL = 4;
  localparam int CFG_MEN = 5;

  localparam int CSR_RST = 0;
  localparam int CSR_TC = 1;
  localparam int CSR_IEN = 2;
  localparam int CSR_PND = 3;
  localparam int CSR_FRZ = 4;

  localparam logic [15:0] RLD_RST = 16'hFFFF;
  localparam logic [7:0] WDC_RST = 8'h0F;
  localparam logic [7:0] MATCH_VAL = 8'h5C;

  typedef struct packed {
    logic [2:0] slow;
    logic [1:0] frz;
    logic [4:0] pre;
    logic [5:0] cfg;
    logic [2:0] div;
    logic [15:0] reload;
    logic [15:0] tcnt;
    logic restart;
    logic tc;
    logic irq_en;
    logic frz_en;
    logic pend;
    logic uf;
    logic irq;
    logic [7:0] wd_val;
    logic [7:0] wd_cnt;
    logic wd_run;
    logic wd_hit;
    logic wd_err;
    logic ack;
    logic [31:0] rdat;
  } twd_state_t;

endpackage

// >>> logic/twd_top.sv
// tick timer and lockable watchdog with a wishbone register slave
//
// Contract
// - locked register ignores writes; its reads return zero here.
// - lock bits, once set, stay set until device reset.
// - config byte: four locks, watchdog clock select, match service enable.
// - watchdog clocked by underflow or by prescaled clock per select.
// - service by count write, or only by 5Ch match write when enabled.
// - prescaler divides slow clock by 1 to 32; other codes reserved.
// - reload register resets to FFFFh and reloads counter on underflow.
// - tick event every reload plus one prescaled clock cycles.
// - control/status byte: restart, flag, irq enable, pending, freeze enable.
// - restart reloads counter at next prescaled edge and self-clears.
// - terminal flag set at zero, cleared by status read, not writable.
// - status read during debug freeze keeps terminal flag.
// - tick interrupt on each zero only while enabled.
// - pending flag high while watchdog write is being transferred.
// - freeze stops watchdog always, tick counter if freeze enabled.
// - count register resets to 0Fh; first write starts watchdog.
// - later count writes restart countdown from new value while match service is disabled.
// - tick counter is 16-bit, decrements per prescaled edge, auto reloads.
// - watchdog 8-bit, idle after reset, only reset stops it.
// - wrong match value or double match service per wd clock errs.
// - watchdog error acts as a device reset.
`timescale 1ns/100ps
module twd_top (
  input wire logic SYS_CLK_IN,
  input wire logic RST_B_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [3:0] WB_SEL_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  input wire logic SLOW_CLK_IN,
  input wire logic DEBUG_FREEZE_IN,
  output logic TICK_IRQ_OUT,
  output logic TICK_UNDERFLOW_OUT,
  output logic WD_ERROR_OUT
);

  twd_pkg::twd_state_t q;
  twd_pkg::twd_state_t d;

  logic slow_rise;
  logic frz;
  logic [4:0] mask;
  logic mask_ok;
  logic tin;
  logic tstep;
  logic uf_evt;
  logic wdclk;
  logic req;
  logic wr;
  logic rd;
  logic err;
  logic svc;
  logic [7:0] wb0;

  //////////////////////////////////////////////////////////////////
  // slow clock edge and prescaled tick enable

  assign slow_rise = q.slow[1] & ~q.slow[2];
  assign frz = q.frz[1];

  always_comb begin
    mask_ok = 1'b1;
    case (q.div)
      3'h0: mask = 5'h00;
      3'h1: mask = 5'h01;
      3'h2: mask = 5'h03;
      3'h3: mask = 5'h07;
      3'h4: mask = 5'h0F;
      3'h5: mask = 5'h1F;
      default: begin
        // reserved codes stop the prescaled clock
        mask = 5'h1F;
        mask_ok = 1'b0;
      end
    endcase
  end

  assign tin = slow_rise & mask_ok & ((q.pre & mask) == mask);
  assign tstep = tin & ~(frz & q.frz_en);
  assign uf_evt = tstep & ~q.restart & (q.tcnt == 16'h0001);
  assign wdclk = (q.cfg[twd_pkg::CFG_WSEL] ? tin : uf_evt) & ~frz;

  //////////////////////////////////////////////////////////////////
  // bus decode

  assign req = WB_CYC_IN & WB_STB_IN & ~q.ack;
  assign wr = req & WB_WE_IN;
  assign rd = req & ~WB_WE_IN;
  assign wb0 = WB_SEL_IN[0] ? WB_DAT_IN[7:0] : 8'h00;

  //////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    err = 1'b0;
    svc = 1'b0;
    // first flop of each synchroniser feeds only the second
    d.slow = {q.slow[1], q.slow[0], SLOW_CLK_IN};
    d.frz = {q.frz[0], DEBUG_FREEZE_IN};
    d.ack = req;
    d.irq = 1'b0;
    d.wd_err = 1'b0;
    d.rdat = 32'h0000_0000;

    if (slow_rise) begin
      d.pre = q.pre + 5'h01;
      // transfer into the watchdog completes on the slow clock
      d.pend = 1'b0;
    end

    // tick counter
    if (tstep) begin
      if (q.restart) begin
        d.tcnt = q.reload;
        d.restart = 1'b0;
      end else if (q.tcnt == 16'h0000 || q.tcnt == 16'h0001) begin
        d.tcnt = (q.tcnt == 16'h0000) ? q.reload : 16'h0000;
      end else begin
        d.tcnt = q.tcnt - 16'h0001;
      end
    end
    if (tstep && q.tcnt == 16'h0000 && !q.restart) begin
      d.tcnt = q.reload;
    end
    if (tstep) begin
      d.uf = uf_evt;
    end

    // watchdog clock
    if (wdclk) begin
      d.wd_hit = 1'b0;
      if (q.wd_run) begin
        if (q.wd_cnt == 8'h00) begin
          err = 1'b1;
        end else begin
          d.wd_cnt = q.wd_cnt - 8'h01;
        end
      end
    end

    // reads
    if (rd) begin
      if (WB_ADR_IN == twd_pkg::ADR_CFG) begin
        if (!q.cfg[twd_pkg::CFG_LCFG]) begin
          d.rdat = {26'h0, q.cfg};
        end
      end else if (WB_ADR_IN == twd_pkg::ADR_PRE) begin
        if (!q.cfg[twd_pkg::CFG_LPRE]) begin
          d.rdat = {29'h0, q.div};
        end
      end else if (WB_ADR_IN == twd_pkg::ADR_RLD) begin
        if (!q.cfg[twd_pkg::CFG_LTCK]) begin
          d.rdat = {16'h0, q.reload};
        end
      end else if (WB_ADR_IN == twd_pkg::ADR_CSR) begin
        if (!q.cfg[twd_pkg::CFG_LTCK]) begin
          d.rdat = {27'h0, q.frz_en, q.pend, q.irq_en, q.tc, q.restart};
          if (!frz) begin
            d.tc = 1'b0;
          end
        end
      end
    end

    // writes
    if (wr && WB_SEL_IN[0]) begin
      if (WB_ADR_IN == twd_pkg::ADR_CFG) begin
        if (!q.cfg[twd_pkg::CFG_LCFG]) begin
          d.cfg[3:0] = q.cfg[3:0] | wb0[3:0];
          d.cfg[5:4] = wb0[5:4];
        end
      end else if (WB_ADR_IN == twd_pkg::ADR_PRE) begin
        if (!q.cfg[twd_pkg::CFG_LPRE]) begin
          d.div = wb0[2:0];
        end
      end else if (WB_ADR_IN == twd_pkg::ADR_CSR) begin
        if (!q.cfg[twd_pkg::CFG_LTCK]) begin
          // terminal flag and pending are not writable
          if (wb0[twd_pkg::CSR_RST]) begin
            d.restart = 1'b1;
          end
          d.irq_en = wb0[twd_pkg::CSR_IEN];
          d.frz_en = wb0[twd_pkg::CSR_FRZ];
        end
      end else if (WB_ADR_IN == twd_pkg::ADR_WDC) begin
        if (!q.cfg[twd_pkg::CFG_LWDC]) begin
          d.wd_val = wb0;
          d.pend = 1'b1;
          if (!q.cfg[twd_pkg::CFG_MEN] || !q.wd_run) begin
            d.wd_cnt = wb0;
            d.wd_run = 1'b1;
          end
        end
      end else if (WB_ADR_IN == twd_pkg::ADR_WDM) begin
        if (q.cfg[twd_pkg::CFG_MEN]) begin
          d.pend = 1'b1;
          if (wb0 != twd_pkg::MATCH_VAL) begin
            err = 1'b1;
          end else if (q.wd_hit) begin
            err = 1'b1;
          end else begin
            svc = 1'b1;
          end
        end
      end
    end

    // byte lanes 0 and 1 of the reload register
    if (wr && WB_ADR_IN == twd_pkg::ADR_RLD && !q.cfg[twd_pkg::CFG_LTCK]) begin
      if (WB_SEL_IN[0]) begin
        d.reload[7:0] = WB_DAT_IN[7:0];
      end
      if (WB_SEL_IN[1]) begin
        d.reload[15:8] = WB_DAT_IN[15:8];
      end
    end

    if (svc) begin
      d.wd_cnt = q.wd_val;
      d.wd_run = 1'b1;
      d.wd_hit = 1'b1;
    end

    // hardware set wins over a status read in the same cycle
    if (uf_evt) begin
      d.tc = 1'b1;
      d.irq = q.irq_en;
    end

    if (err || !RST_B_IN) begin
      // error restores the reset state, locks included
      d = '0;
      // synchronisers keep shifting so no pin edge is lost across a reset
      d.slow = {q.slow[1], q.slow[0], SLOW_CLK_IN};
      d.frz = {q.frz[0], DEBUG_FREEZE_IN};
      d.reload = twd_pkg::RLD_RST;
      d.tcnt = twd_pkg::RLD_RST;
      d.wd_val = twd_pkg::WDC_RST;
      d.wd_err = err & RST_B_IN;
      d.ack = req & RST_B_IN;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    q <= d;
  end

  assign WB_DAT_OUT = q.rdat;
  assign WB_ACK_OUT = q.ack;
  assign TICK_IRQ_OUT = q.irq;
  assign TICK_UNDERFLOW_OUT = q.uf;
  assign WD_ERROR_OUT = q.wd_err;

  //////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  a_lock_sticky: assert property (
    !err |=> (($past(q.cfg[3:0]) & ~q.cfg[3:0]) == 4'h0))
    else $error("lock bit cleared without reset");

  a_cfg_locked: assert property (
    wr && WB_ADR_IN == twd_pkg::ADR_CFG && q.cfg[0] && !err |=> q.cfg == $past(q.cfg))
    else $error("locked config changed");

  a_tick_locked: assert property (
    wr && WB_ADR_IN == twd_pkg::ADR_RLD && q.cfg[2] && !err |=> q.reload == $past(q.reload))
    else $error("locked reload changed");

  a_restart_load: assert property (
    tstep && q.restart && !wr && !err |=> !q.restart && q.tcnt == $past(q.reload))
    else $error("restart did not reload");

  a_tc_set: assert property (
    uf_evt && !err |=> q.tc)
    else $error("terminal flag not set");

  a_tc_freeze: assert property (
    q.tc && frz && !err |=> q.tc)
    else $error("terminal flag lost in freeze");

  a_irq_gate: assert property (
    q.irq |-> $past(q.irq_en) && $past(uf_evt))
    else $error("interrupt without enabled event");

  a_wd_freeze: assert property (
    frz && !wr && !err |=> q.wd_cnt == $past(q.wd_cnt))
    else $error("watchdog moved in freeze");

  a_wd_late: assert property (
    wdclk && q.wd_run && q.wd_cnt == 8'h00 |=> q.wd_err ##1 !q.wd_run)
    else $error("late service not an error");

  a_bad_match: assert property (
    wr && WB_SEL_IN[0] && WB_ADR_IN == twd_pkg::ADR_WDM && q.cfg[5] && wb0 != twd_pkg::MATCH_VAL
    |=> q.wd_err && q.cfg == 6'h00)
    else $error("bad match value not an error");

  a_wd_idle: assert property (
    !q.wd_run && !wr |=> q.wd_cnt == $past(q.wd_cnt))
    else $error("watchdog counts before start");

  //////////////////////////////////////////////////////////////////
  // register and counter behaviour

  a_pend_set: assert property (
    wr && WB_SEL_IN[0] && WB_ADR_IN == twd_pkg::ADR_WDC && !q.cfg[3] && !err |=> q.pend)
    else $error("pending not set by count write");

  a_pend_clear: assert property (
    slow_rise && !wr |=> !q.pend)
    else $error("pending not cleared by slow edge");

  a_csr_locked: assert property (
    wr && WB_ADR_IN == twd_pkg::ADR_CSR && q.cfg[2] && !err
    |=> q.irq_en == $past(q.irq_en) && q.frz_en == $past(q.frz_en))
    else $error("locked control changed");

  a_pre_locked: assert property (
    wr && WB_ADR_IN == twd_pkg::ADR_PRE && q.cfg[1] && !err |=> q.div == $past(q.div))
    else $error("locked prescaler changed");

  a_lock_read: assert property (
    rd && WB_ADR_IN == twd_pkg::ADR_PRE && q.cfg[1] |=> q.rdat == 32'h0000_0000)
    else $error("locked prescaler read not zero");

  a_double_match: assert property (
    wr && WB_SEL_IN[0] && WB_ADR_IN == twd_pkg::ADR_WDM && q.cfg[5] && q.wd_hit |=> q.wd_err)
    else $error("second match service not an error");

  a_wdc_service: assert property (
    wr && WB_SEL_IN[0] && WB_ADR_IN == twd_pkg::ADR_WDC && !q.cfg[3] && !q.cfg[5] && !err
    |=> q.wd_run && q.wd_cnt == $past(wb0))
    else $error("count write did not reload watchdog");

  a_uf_level: assert property (
    uf_evt && !err |=> q.uf)
    else $error("underflow level not raised");

  a_irq_enabled: assert property (
    uf_evt && q.irq_en && !err |=> q.irq)
    else $error("enabled interrupt missing");

  a_reload_lane: assert property (
    wr && WB_ADR_IN == twd_pkg::ADR_RLD && !q.cfg[2] && WB_SEL_IN[1:0] == 2'h3 && !err
    |=> q.reload == $past(WB_DAT_IN[15:0]))
    else $error("reload write lost");

  a_tick_reload: assert property (
    tstep && !q.restart && q.tcnt == 16'h0000 && !err |=> q.tcnt == $past(q.reload))
    else $error("tick counter not reloaded at zero");

  a_tick_dec: assert property (
    tstep && !q.restart && q.tcnt > 16'h0001 && !err |=> q.tcnt == $past(q.tcnt) - 16'h0001)
    else $error("tick counter did not decrement");

  a_wd_count: assert property (
    wdclk && q.wd_run && q.wd_cnt != 8'h00 && !wr && !err |=> q.wd_cnt == $past(q.wd_cnt) - 8'h01)
    else $error("watchdog did not decrement");

  a_ack_pulse: assert property (
    q.ack |=> !q.ack)
    else $error("ack held two cycles");

  c_underflow: cover property (uf_evt ##[1:300] uf_evt);
  c_wd_error: cover property (q.wd_run ##[1:1000] q.wd_err);
  c_match_svc: cover property (svc);
  c_locked: cover property (q.cfg[3:0] == 4'hF);

endmodule // twd_top

// >>> bench/tick_timer_watchdog_regs_test.sv
// self-checking bench for the tick timer and watchdog register block
`timescale 1ns/100ps
`define CK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tick_timer_watchdog_regs_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic frz = 1'b0;
  logic slow = 1'b0;
  logic slow_en = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [3:0] sc = 4'h0;
  wire logic [31:0] dout;
  wire logic ack;
  wire logic irq;
  wire logic uf;
  wire logic err;
  int bad_count = 0;
  int checked = 0;
  int n;

  always #4 clk = ~clk;

  // slow clock at an eighth of the system clock; holding it stops the prescaled domain
  always @(posedge clk) begin
    if (slow_en) sc <= sc + 4'h1;
    slow <= sc[2];
  end

  twd_top twd_top_i (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_DAT_IN(wdat), .WB_SEL_IN(4'hF), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack),
    .SLOW_CLK_IN(slow), .DEBUG_FREEZE_IN(frz), .TICK_IRQ_OUT(irq), .TICK_UNDERFLOW_OUT(uf), .WD_ERROR_OUT(err));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic rst;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask

  // entered just after an edge; holds the request until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin @(posedge clk); k++; end while (ack !== 1'b1 && k < 20);
    if (k >= 20) bad_count++;
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CK(rdat, e)
  endtask

  // counts cycles until the chosen pulse is sampled, giving up at lim
  task automatic wait_sig(input int lim, input bit use_err);
    n = 0;
    do begin @(posedge clk); n++; end while ((use_err ? err : irq) !== 1'b1 && n < lim);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(twd_pkg::ADR_CFG, 32'h0);
    rd(twd_pkg::ADR_PRE, 32'h0);
    rd(twd_pkg::ADR_RLD, 32'h0000FFFF);
    rd(twd_pkg::ADR_CSR, 32'h0);
    rd(8'h20, 32'h0);
  endtask

  task automatic t_fields;
    wr(twd_pkg::ADR_PRE, 32'hFD);
    rd(twd_pkg::ADR_PRE, 32'h05);
    wr(twd_pkg::ADR_CSR, 32'hFA);
    rd(twd_pkg::ADR_CSR, 32'h10);
    wr(twd_pkg::ADR_CFG, 32'hC0);
    rd(twd_pkg::ADR_CFG, 32'h0);
    wr(twd_pkg::ADR_PRE, 32'h0);
    wr(twd_pkg::ADR_CSR, 32'h0);
  endtask

  task automatic t_tick;
    wr(twd_pkg::ADR_RLD, 32'h3);
    wr(twd_pkg::ADR_CSR, 32'h05);
    wait_sig(200, 1'b0);
    `CK(uf, 1'b1)
    wait_sig(100, 1'b0);
    `CK(n, 32)
    rd(twd_pkg::ADR_CSR, 32'h06);
    rd(twd_pkg::ADR_CSR, 32'h04);
    frz <= 1'b1;
    wait_sig(100, 1'b0);
    rd(twd_pkg::ADR_CSR, 32'h06);
    rd(twd_pkg::ADR_CSR, 32'h06);
    wr(twd_pkg::ADR_CSR, 32'h14);
    wait_sig(100, 1'b0);
    `CK(n, 100)
    frz <= 1'b0;
    wait_sig(100, 1'b0);
    `CK(n < 100, 1'b1)
    wr(twd_pkg::ADR_CSR, 32'h0);
    wait_sig(100, 1'b0);
    `CK(n, 100)
  endtask

  task automatic t_lock;
    wr(twd_pkg::ADR_RLD, 32'h3);
    wr(twd_pkg::ADR_CSR, 32'h05);
    wr(twd_pkg::ADR_CFG, 32'h02);
    wr(twd_pkg::ADR_CFG, 32'h00);
    rd(twd_pkg::ADR_CFG, 32'h02);
    rd(twd_pkg::ADR_PRE, 32'h0);
    wr(twd_pkg::ADR_CFG, 32'h04);
    rd(twd_pkg::ADR_CFG, 32'h06);
    wr(twd_pkg::ADR_CSR, 32'h0);
    wait_sig(100, 1'b0);
    `CK(n < 100, 1'b1)
  endtask

  task automatic t_wd;
    wr(twd_pkg::ADR_CFG, 32'h10);
    slow_en <= 1'b0;
    wr(twd_pkg::ADR_WDC, 32'h3);
    rd(twd_pkg::ADR_CSR, 32'h08);
    wr(twd_pkg::ADR_WDM, 32'h11);
    slow_en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wait_sig(16, 1'b1);
      `CK(n, 16)
      wr(twd_pkg::ADR_WDC, 32'h3);
    end
    wait_sig(16, 1'b1);
    rd(twd_pkg::ADR_CSR, 32'h0);
    frz <= 1'b1;
    wait_sig(100, 1'b1);
    `CK(n, 100)
    frz <= 1'b0;
    wait_sig(100, 1'b1);
    `CK(n < 100, 1'b1)
    rd(twd_pkg::ADR_CFG, 32'h0);
  endtask

  task automatic t_match;
    wr(twd_pkg::ADR_CFG, 32'h30);
    wr(twd_pkg::ADR_WDC, 32'h40);
    wr(twd_pkg::ADR_WDM, {24'h0, twd_pkg::MATCH_VAL});
    rd(twd_pkg::ADR_CFG, 32'h30);
    wr(twd_pkg::ADR_WDM, 32'h5B);
    rd(twd_pkg::ADR_CFG, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst;
    t_reset;
    t_fields;
    t_tick;
    rst;
    t_lock;
    rst;
    t_wd;
    rst;
    t_match;
    tally_and_finish;
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    tally_and_finish;
  end
endmodule // tick_timer_watchdog_regs_test
